// ===== drbc_disp_model.sv
// Purpose: Behavioural memory dispatcher facing the buffer control
// Assumes: Request is a level, grant a one-cycle pulse
// Notes:   Tracks the memory address to show the modifier's effect
`timescale 1ns/1ps
`default_nettype none
module drbc_disp_model
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Buffer control side
   input  wire logic        req_i,
   input  wire logic        mode_i,
   input  wire logic [1:0]  sub_i,
   output var  logic        ack_o,
   // Observation
   output var  logic [7:0]  acks_o,
   output var  logic [15:0] addr_o
);
   logic [3:0] wait_reg;
   // Quick and slow grants alternate so both request spacings are exercised
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ack_o    <= 1'b0;
         acks_o   <= 8'h00;
         addr_o   <= 16'h0000;
         wait_reg <= 4'h0;
      end
      else if (ack_o)
      begin
         ack_o    <= 1'b0;
         wait_reg <= 4'h0;
      end
      else if (req_i && wait_reg == (acks_o[0] ? 4'h7 : 4'h1))
      begin
         ack_o  <= 1'b1;
         acks_o <= acks_o + 8'h01;
         addr_o <= addr_o + {15'h0000, mode_i} - (sub_i[0] ? 16'h09C3 : 16'h0000);
      end
      else if (req_i)
         wait_reg <= wait_reg + 4'h1;
   end
endmodule // drbc_disp_model
`default_nettype wire

// ===== drbc_props.sv
// Purpose: Port-level checks for drbc_top
// Assumes: Bound to every drbc_top instance
// Notes:   Outputs are judged one edge after their cause
`timescale 1ns/1ps
`default_nettype none
module drbc_props
(
   // Clock and reset
   input wire logic        CLOCK_I, RST_N_I,
   // Digit path
   input wire logic [4:0]  CHANNEL_READY_I, ALIGNED_DIGIT_BITS_I,
   input wire logic        ALIGNED_DIGIT_SHIFT_O, END_OF_SECTOR_O,
   // Sector control and instructions
   input wire logic        FIRST_SENTINEL_SEARCH_START_I, SYNCHRONIZER_ERROR_I,
   input wire logic        SYNCHRONIZER_CLEAR_I, ERROR_INSERT_I, START_INSTR_I,
   input wire logic        CONTINUE_INSTR_I, READING_ACTIVE_I,
   // Buffer and dispatcher side
   input wire logic [11:0] ODD_BUFFER_DIGIT_SELECT_O, EVEN_BUFFER_DIGIT_SELECT_O,
   input wire logic        BUFFER_DRIVE_ENABLE_O, MEMORY_TRANSFER_REQUEST_O,
   input wire logic        WORD_COUNT_EVEN_O, WORD_COUNT_ODD_O,
   input wire logic [1:0]  BAND_WRAP_SUBTRACT_O,
   // Errors
   input wire logic        START_ERROR_O, CONTINUE_ERROR_O, INFORMATION_PARITY_ERROR_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   wire rdy = CHANNEL_READY_I == 5'h1F;
   wire clr = SYNCHRONIZER_ERROR_I || SYNCHRONIZER_CLEAR_I;

   shift_follows_a: assert property (rdy |=> ALIGNED_DIGIT_SHIFT_O)
      else $error("no shift after full channels");
   shift_gated_a: assert property (!rdy |=> !ALIGNED_DIGIT_SHIFT_O)
      else $error("shift without full channels");
   select_gate_a: assert property
      (|{ODD_BUFFER_DIGIT_SELECT_O, EVEN_BUFFER_DIGIT_SELECT_O} |->
       $onehot0({ODD_BUFFER_DIGIT_SELECT_O, EVEN_BUFFER_DIGIT_SELECT_O}) &&
       $past(BUFFER_DRIVE_ENABLE_O) && $past(rdy))
      else $error("select without enable or shift");
   word_parity_a: assert property (WORD_COUNT_EVEN_O != WORD_COUNT_ODD_O)
      else $error("odd and even indications agree");
   enable_set_a: assert property
      (FIRST_SENTINEL_SEARCH_START_I && !clr && !ERROR_INSERT_I && !rdy
       |=> BUFFER_DRIVE_ENABLE_O)
      else $error("enable not set at sector start");
   enable_clear_a: assert property ((clr || ERROR_INSERT_I) |=> !BUFFER_DRIVE_ENABLE_O)
      else $error("enable survived a clear");
   request_drop_a: assert property (clr |=> !MEMORY_TRANSFER_REQUEST_O)
      else $error("request survived a clear");
   request_cause_a: assert property ($rose(MEMORY_TRANSFER_REQUEST_O) |-> $past(rdy))
      else $error("request rose without a digit step");
   start_err_a: assert property (START_INSTR_I && READING_ACTIVE_I |=> START_ERROR_O)
      else $error("start while reading not flagged");
   cont_err_a: assert property
      (CONTINUE_ERROR_O == $past(CONTINUE_INSTR_I && !READING_ACTIVE_I))
      else $error("continue error mismatch");
   parity_err_a: assert property
      (rdy && !ERROR_INSERT_I |=> INFORMATION_PARITY_ERROR_O ==
       ((~^$past(ALIGNED_DIGIT_BITS_I)) && $past(ALIGNED_DIGIT_BITS_I) != 5'h17))
      else $error("parity error mismatch");
   sentinel_end_a: assert property (rdy && ALIGNED_DIGIT_BITS_I == 5'h17 |=> END_OF_SECTOR_O)
      else $error("sentinel not reported");

   cover property ($rose(MEMORY_TRANSFER_REQUEST_O));
   cover property (BAND_WRAP_SUBTRACT_O == 2'h3);
   cover property (END_OF_SECTOR_O && !INFORMATION_PARITY_ERROR_O);
endmodule // drbc_props

bind drbc_top drbc_props i_drbc_props (.*);
`default_nettype wire

// ===== drbc_regs.vh
// Purpose: Constants for the drum-read buffer control block
// Assumes: Included by drbc_top.v only
// Notes:   Byte offsets on the plain register port
`ifndef DRBC_REGS_VH
`define DRBC_REGS_VH

// Register byte offsets
`define DRBC_CTRL_OFS        4'h0
`define DRBC_STATUS_OFS      4'h4
`define DRBC_COUNT_OFS       4'h8
`define DRBC_ERRLOG_OFS      4'hC

// CTRL fields
`define DRBC_CTRL_MODE1_BIT  0
`define DRBC_CTRL_MODE2_BIT  1
`define DRBC_CTRL_RESET      2'h1

// STATUS fields
`define DRBC_ST_ENABLE_BIT   0
`define DRBC_ST_REQUEST_BIT  1
`define DRBC_ST_ZERO_BIT     2
`define DRBC_ST_SUBTR_BIT    3
`define DRBC_ST_HUNDRED_BIT  4

// COUNT fields
`define DRBC_CNT_DIGIT_LSB   0
`define DRBC_CNT_WORD_LSB    8

// ERRLOG fields, write one to clear
`define DRBC_ERR_START_BIT   0
`define DRBC_ERR_CONT_BIT    1
`define DRBC_ERR_PARITY_BIT  2
`define DRBC_ERR_FAULT_BIT   3

// Counter values
`define DRBC_DIGIT_FIRST     4'h0
`define DRBC_DIGIT_BEFORE    4'hA
`define DRBC_DIGIT_LAST      4'hB
`define DRBC_WORD_ZERO       7'h00
`define DRBC_WORD_99         7'h63
`define DRBC_WORD_100        7'h64

// End-of-sector sentinel digit
`define DRBC_END_SENTINEL    5'h17

`endif

// ===== drbc_top.v
// Purpose: Buffer control of a drum-read synchronizer: digit and word
//          counting, buffer select, memory requests, band wrap, errors
// Assumes: One synchronizer clock; all inputs come from logic on it
// Notes:   Digit count is held as index 0..11 for counts 1..12
//
// Overview of operation
// - Provide 12 odd-buffer and 12 even-buffer digit select outputs.
// - Set buffer-drive enable at sector start; clear after hundredth word stored.
// - Error, clear or error-insert also clears buffer-drive enable.
// - Word parity picks buffer group; digit count picks the select inside it.
// - Sector-address-full clears digit counter to its first state.
// - Each aligned digit steps digit counter; after 12 it returns to 1.
// - Word counter is seven-bit straight binary, counting to 100.
// - Word counter clears at sector-address-full, steps on each digit counter wrap below 100.
// - Word counter low bit tells dispatcher odd or even buffer.
// - Count 99 arms subtract; its pulse clears enable at step to 100.
// - Word count 100 raises sector-complete toward the length checker.
// - Digit counter reaching last state raises a memory-transfer request while buffer-drive enable is set.
// - Dispatcher acknowledge, error or clear withdraws the request.
// - Mode signals tell dispatcher to add 1 per successive address.
// - Mode 2 subtracts 2499 on sector 24 last word; sentinel clears flags.
// - Sector-zero flag sets only when address register holds sector 00.
// - Subtract sets at last digit of word 99 with sector-zero; both doubled.
// - Start while reading, or too late for the sector, is a start error.
// - Continue while not reading is a continue error.
// - Aligned digit with even ones is a parity error, except sentinel 10111.
// - Sentinel not seen as even by the checker is a checker fault.
// - Digit shifts only once all five channel registers hold a bit.
//
// The address map and strobed register access were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none
`include "drbc_regs.vh"

module drbc_top
(
   // Clock and reset
   input  wire        CLOCK_I,
   input  wire        RST_N_I,
   // Register port
   input  wire [3:0]  ADDR_I,
   input  wire [15:0] WDATA_I,
   input  wire        WR_I,
   input  wire        RD_I,
   output reg  [15:0] RDATA_O,
   // Skew-correction side
   input  wire [4:0]  CHANNEL_READY_I,
   input  wire [4:0]  ALIGNED_DIGIT_BITS_I,
   output reg         ALIGNED_DIGIT_SHIFT_O,
   output reg  [4:0]  ALIGNED_DIGIT_O,
   output reg         END_OF_SECTOR_O,
   // Sector control
   input  wire        FIRST_SENTINEL_SEARCH_START_I,
   input  wire        SECTOR_ADDRESS_FULL_I,
   input  wire        ADDRESS_SENTINEL_FOUND_I,
   input  wire        SECTOR_ADDRESS_ZERO_I,
   input  wire        SYNCHRONIZER_ERROR_I,
   input  wire        SYNCHRONIZER_CLEAR_I,
   input  wire        ERROR_INSERT_I,
   // Instruction checks
   input  wire        START_INSTR_I,
   input  wire        CONTINUE_INSTR_I,
   input  wire        READING_ACTIVE_I,
   input  wire        SET_SECTOR_CHANGE_SYNC_I,
   input  wire        SECTOR_CHANGE_FLAG_I,
   // Buffer write drivers
   output reg  [11:0] ODD_BUFFER_DIGIT_SELECT_O,
   output reg  [11:0] EVEN_BUFFER_DIGIT_SELECT_O,
   output reg         BUFFER_DRIVE_ENABLE_O,
   // Dispatcher
   input  wire        MEMORY_TRANSFER_ACK_I,
   output reg         MEMORY_TRANSFER_REQUEST_O,
   output reg         WORD_COUNT_EVEN_O,
   output reg         WORD_COUNT_ODD_O,
   output reg         MODE_ONE_SELECT_O,
   output reg         MODE_TWO_SELECT_O,
   output reg  [1:0]  BAND_WRAP_SUBTRACT_O,
   output reg         WORD_COUNT_HUNDRED_O,
   // Errors toward the error latch
   output reg         START_ERROR_O,
   output reg         CONTINUE_ERROR_O,
   output reg         INFORMATION_PARITY_ERROR_O,
   output reg         PARITY_CHECKER_FAULT_O
);

   reg  [3:0]  digit_count_reg;
   reg  [3:0]  digit_count_next;
   reg  [6:0]  word_count_reg;
   reg  [6:0]  word_count_next;
   reg  [1:0]  ctrl_reg;
   reg  [3:0]  errlog_reg;
   reg  [3:0]  errlog_next;
   reg  [1:0]  sector_zero_reg;
   reg         wc99_seen_reg;
   reg         enable_next;
   reg         request_next;
   reg  [1:0]  subtract_next;
   reg  [1:0]  sector_zero_next;
   reg  [15:0] rdata_next;

   wire        any_reset_event;
   wire        aligned_digit_shift;
   wire        digit_count_last;
   wire        word_count_step;
   wire        word_count_ninety_nine;
   wire        word_ninety_nine_pulse;
   wire        end_of_sector;
   wire        digit_even_ones;
   wire        parity_err;
   wire        fault_err;
   wire        start_err;
   wire        cont_err;
   wire [11:0] select_onehot;

   assign any_reset_event     = SYNCHRONIZER_ERROR_I | SYNCHRONIZER_CLEAR_I;
   // Both present strobes come from the same all-ready condition
   assign aligned_digit_shift = &CHANNEL_READY_I;
   assign digit_count_last    = (digit_count_reg == `DRBC_DIGIT_LAST);
   assign word_count_step     = aligned_digit_shift & digit_count_last;
   assign word_count_ninety_nine = (word_count_reg == `DRBC_WORD_99);
   // Pulse form of count 99, live on every cycle at 99 up to the step that leaves it
   assign word_ninety_nine_pulse = word_count_ninety_nine & ~wc99_seen_reg;

   assign end_of_sector   = (aligned_digit_shift &
                             (ALIGNED_DIGIT_BITS_I == `DRBC_END_SENTINEL))
                            | ERROR_INSERT_I;
   assign digit_even_ones = ~^ALIGNED_DIGIT_BITS_I;
   assign parity_err      = aligned_digit_shift & digit_even_ones
                            & ~end_of_sector;
   assign fault_err       = end_of_sector & ~digit_even_ones;
   assign start_err       = START_INSTR_I &
                            (READING_ACTIVE_I |
                             (SECTOR_ADDRESS_FULL_I & SET_SECTOR_CHANGE_SYNC_I &
                              SECTOR_CHANGE_FLAG_I));
   assign cont_err        = CONTINUE_INSTR_I & ~READING_ACTIVE_I;

   genvar gi;
   generate
      for (gi = 0; gi < 12; gi = gi + 1)
      begin : g_select
         assign select_onehot[gi] = (digit_count_reg == gi[3:0]);
      end
   endgenerate

   // Digit counter
   always @*
   begin
      digit_count_next = digit_count_reg;
      if (SECTOR_ADDRESS_FULL_I)
         digit_count_next = `DRBC_DIGIT_FIRST;
      else if (aligned_digit_shift)
      begin
         if (digit_count_last)
            digit_count_next = `DRBC_DIGIT_FIRST;
         else
            digit_count_next = digit_count_reg + 4'h1;
      end
   end

   // Word counter, holds at 100 so a runaway sector cannot wrap it
   always @*
   begin
      word_count_next = word_count_reg;
      if (SECTOR_ADDRESS_FULL_I)
         word_count_next = `DRBC_WORD_ZERO;
      else if (word_count_step && word_count_reg != `DRBC_WORD_100)
         word_count_next = word_count_reg + 7'h01;
   end

   // Buffer-drive enable: clearing causes take priority over the set
   always @*
   begin
      enable_next = BUFFER_DRIVE_ENABLE_O;
      if (FIRST_SENTINEL_SEARCH_START_I)
         enable_next = 1'b1;
      if (word_count_step && word_ninety_nine_pulse)
         enable_next = 1'b0;
      if (any_reset_event || ERROR_INSERT_I)
         enable_next = 1'b0;
   end

   // Request: a new request wins over an acknowledge in the same cycle
   always @*
   begin
      request_next = MEMORY_TRANSFER_REQUEST_O;
      if (MEMORY_TRANSFER_ACK_I)
         request_next = 1'b0;
      if (aligned_digit_shift && digit_count_reg == `DRBC_DIGIT_BEFORE &&
          BUFFER_DRIVE_ENABLE_O)
         request_next = 1'b1;
      if (any_reset_event)
         request_next = 1'b0;
   end

   // Band-wrap flags, two copies each for checking
   always @*
   begin
      sector_zero_next = sector_zero_reg;
      subtract_next    = BAND_WRAP_SUBTRACT_O;
      if (ADDRESS_SENTINEL_FOUND_I)
      begin
         sector_zero_next = 2'h0;
         subtract_next    = 2'h0;
      end
      if (SECTOR_ADDRESS_FULL_I && SECTOR_ADDRESS_ZERO_I)
         sector_zero_next = 2'h3;
      if (ctrl_reg[`DRBC_CTRL_MODE2_BIT] && digit_count_last &&
          word_count_ninety_nine)
      begin
         if (sector_zero_reg[0])
            subtract_next[0] = 1'b1;
         if (sector_zero_reg[1])
            subtract_next[1] = 1'b1;
      end
   end

   // Error log: a new error wins over a write-one clear
   always @*
   begin
      errlog_next = errlog_reg;
      if (WR_I && ADDR_I == `DRBC_ERRLOG_OFS)
         errlog_next = errlog_reg & ~WDATA_I[3:0];
      if (start_err)
         errlog_next[`DRBC_ERR_START_BIT] = 1'b1;
      if (cont_err)
         errlog_next[`DRBC_ERR_CONT_BIT] = 1'b1;
      if (parity_err)
         errlog_next[`DRBC_ERR_PARITY_BIT] = 1'b1;
      if (fault_err)
         errlog_next[`DRBC_ERR_FAULT_BIT] = 1'b1;
   end

   // Read mux, data valid only in the cycle after the strobe
   always @*
   begin
      rdata_next = 16'h0000;
      if (RD_I)
      begin
         case (ADDR_I)
            `DRBC_CTRL_OFS:
               rdata_next = {14'h0000, ctrl_reg};
            `DRBC_STATUS_OFS:
               rdata_next = {11'h000, WORD_COUNT_HUNDRED_O,
                             BAND_WRAP_SUBTRACT_O[0], sector_zero_reg[0],
                             MEMORY_TRANSFER_REQUEST_O, BUFFER_DRIVE_ENABLE_O};
            `DRBC_COUNT_OFS:
               rdata_next = {1'b0, word_count_reg, 4'h0, digit_count_reg};
            `DRBC_ERRLOG_OFS:
               rdata_next = {12'h000, errlog_reg};
            default:
               rdata_next = 16'h0000;
         endcase
      end
   end

   // All state on the one synchronizer clock
   always @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         digit_count_reg            <= `DRBC_DIGIT_FIRST;
         word_count_reg             <= `DRBC_WORD_ZERO;
         ctrl_reg                   <= `DRBC_CTRL_RESET;
         errlog_reg                 <= 4'h0;
         sector_zero_reg            <= 2'h0;
         wc99_seen_reg              <= 1'b0;
         RDATA_O                    <= 16'h0000;
         ALIGNED_DIGIT_SHIFT_O      <= 1'b0;
         ALIGNED_DIGIT_O            <= 5'h00;
         END_OF_SECTOR_O            <= 1'b0;
         ODD_BUFFER_DIGIT_SELECT_O  <= 12'h000;
         EVEN_BUFFER_DIGIT_SELECT_O <= 12'h000;
         BUFFER_DRIVE_ENABLE_O      <= 1'b0;
         MEMORY_TRANSFER_REQUEST_O  <= 1'b0;
         WORD_COUNT_EVEN_O          <= 1'b1;
         WORD_COUNT_ODD_O           <= 1'b0;
         MODE_ONE_SELECT_O          <= 1'b0;
         MODE_TWO_SELECT_O          <= 1'b0;
         BAND_WRAP_SUBTRACT_O       <= 2'h0;
         WORD_COUNT_HUNDRED_O       <= 1'b0;
         START_ERROR_O              <= 1'b0;
         CONTINUE_ERROR_O           <= 1'b0;
         INFORMATION_PARITY_ERROR_O <= 1'b0;
         PARITY_CHECKER_FAULT_O     <= 1'b0;
      end
      else
      begin
         digit_count_reg <= digit_count_next;
         word_count_reg  <= word_count_next;
         errlog_reg      <= errlog_next;
         sector_zero_reg <= sector_zero_next;
         if (WR_I && ADDR_I == `DRBC_CTRL_OFS)
            ctrl_reg <= WDATA_I[1:0];
         // Remember that the 99 pulse was used so it fires once
         if (SECTOR_ADDRESS_FULL_I)
            wc99_seen_reg <= 1'b0;
         else if (word_count_step && word_count_ninety_nine)
            wc99_seen_reg <= 1'b1;
         RDATA_O               <= rdata_next;
         ALIGNED_DIGIT_SHIFT_O <= aligned_digit_shift;
         if (aligned_digit_shift)
            ALIGNED_DIGIT_O <= ALIGNED_DIGIT_BITS_I;
         END_OF_SECTOR_O <= end_of_sector;
         // Select pulses accompany the digit being shifted out
         if (aligned_digit_shift && BUFFER_DRIVE_ENABLE_O)
         begin
            ODD_BUFFER_DIGIT_SELECT_O  <= word_count_reg[0] ?
                                          select_onehot : 12'h000;
            EVEN_BUFFER_DIGIT_SELECT_O <= word_count_reg[0] ?
                                          12'h000 : select_onehot;
         end
         else
         begin
            ODD_BUFFER_DIGIT_SELECT_O  <= 12'h000;
            EVEN_BUFFER_DIGIT_SELECT_O <= 12'h000;
         end
         BUFFER_DRIVE_ENABLE_O     <= enable_next;
         MEMORY_TRANSFER_REQUEST_O <= request_next;
         WORD_COUNT_EVEN_O         <= ~word_count_next[0];
         WORD_COUNT_ODD_O          <= word_count_next[0];
         MODE_ONE_SELECT_O         <= ctrl_reg[`DRBC_CTRL_MODE1_BIT];
         MODE_TWO_SELECT_O         <= ctrl_reg[`DRBC_CTRL_MODE2_BIT];
         BAND_WRAP_SUBTRACT_O      <= subtract_next;
         WORD_COUNT_HUNDRED_O      <= (word_count_next == `DRBC_WORD_100);
         START_ERROR_O              <= start_err;
         CONTINUE_ERROR_O           <= cont_err;
         INFORMATION_PARITY_ERROR_O <= parity_err;
         PARITY_CHECKER_FAULT_O     <= fault_err;
      end
   end

endmodule // drbc_top

`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for drbc_top
// Assumes: Dispatcher model answers every request
// Notes:   Outputs are checked 1 ns after the edge that updates them
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        CLOCK_I;
   logic        RST_N_I;
   logic        WR_I;
   logic        RD_I;
   logic [3:0]  ADDR_I;
   logic [15:0] WDATA_I;
   logic [4:0]  rdy;
   logic [4:0]  bits;
   logic [11:0] ctl;
   int          fails;
   int          checked;
   wire  [15:0] rdata;
   wire  [15:0] addr;
   wire  [11:0] osel;
   wire  [11:0] esel;
   wire  [4:0]  adig;
   wire  [7:0]  acks;
   wire  [1:0]  sub;
   wire         eos, en, req, ack, wod, wev, m1, m2, hund, se, ce, pe, pf;

   drbc_top i_drbc_top
   (
      .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
      .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(rdata), .CHANNEL_READY_I(rdy),
      .ALIGNED_DIGIT_BITS_I(bits), .ALIGNED_DIGIT_SHIFT_O(), .ALIGNED_DIGIT_O(adig),
      .END_OF_SECTOR_O(eos), .FIRST_SENTINEL_SEARCH_START_I(ctl[0]),
      .SECTOR_ADDRESS_FULL_I(ctl[1]), .ADDRESS_SENTINEL_FOUND_I(ctl[2]),
      .SECTOR_ADDRESS_ZERO_I(ctl[3]), .SYNCHRONIZER_ERROR_I(ctl[4]),
      .SYNCHRONIZER_CLEAR_I(ctl[5]), .ERROR_INSERT_I(ctl[6]), .START_INSTR_I(ctl[7]),
      .CONTINUE_INSTR_I(ctl[8]), .READING_ACTIVE_I(ctl[9]),
      .SET_SECTOR_CHANGE_SYNC_I(ctl[10]), .SECTOR_CHANGE_FLAG_I(ctl[11]),
      .ODD_BUFFER_DIGIT_SELECT_O(osel), .EVEN_BUFFER_DIGIT_SELECT_O(esel),
      .BUFFER_DRIVE_ENABLE_O(en), .MEMORY_TRANSFER_ACK_I(ack),
      .MEMORY_TRANSFER_REQUEST_O(req), .WORD_COUNT_EVEN_O(wev), .WORD_COUNT_ODD_O(wod),
      .MODE_ONE_SELECT_O(m1), .MODE_TWO_SELECT_O(m2), .BAND_WRAP_SUBTRACT_O(sub),
      .WORD_COUNT_HUNDRED_O(hund), .START_ERROR_O(se), .CONTINUE_ERROR_O(ce),
      .INFORMATION_PARITY_ERROR_O(pe), .PARITY_CHECKER_FAULT_O(pf)
   );

   drbc_disp_model i_drbc_disp_model
   (
      .clk_i(CLOCK_I), .rst_n_i(RST_N_I), .req_i(req), .mode_i(m1 | m2),
      .sub_i(sub), .ack_o(ack), .acks_o(acks), .addr_o(addr)
   );

   initial
   begin
      CLOCK_I = 1'b0;
      forever #5 CLOCK_I = ~CLOCK_I;
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      fails += (g !== e);
      if (g !== e)
         $display("[FAIL] %s expected %h seen %h", n, e, g);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLOCK_I);
      ADDR_I  <= a;
      WDATA_I <= d;
      WR_I    <= 1'b1;
      @(posedge CLOCK_I);
      WR_I    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge CLOCK_I);
      ADDR_I <= a;
      RD_I   <= 1'b1;
      @(posedge CLOCK_I);
      RD_I   <= 1'b0;
      #1;
      chk("rdata", e, rdata);
   endtask

   // Control lines are raised together for one cycle, levels included
   task automatic pulse(input logic [11:0] v);
      @(posedge CLOCK_I);
      ctl <= v;
      @(posedge CLOCK_I);
      ctl <= 12'h000;
      #1;
   endtask

   task automatic dig(input logic [4:0] b);
      @(posedge CLOCK_I);
      rdy  <= 5'h1F;
      bits <= b;
      @(posedge CLOCK_I);
      rdy  <= 5'h00;
      #1;
   endtask

   task automatic t_regs;
      rd(4'h0, 16'h0001);
      rd(4'h2, 16'h0000);
      rd(4'h4, 16'h0000);
   endtask

   task automatic t_sector;
      wr(4'h0, 16'h0002);
      pulse(12'h001);
      pulse(12'h00A);
      chk("mode2", 16'h0001, m2);
      chk("mode1", 16'h0000, m1);
      rd(4'h8, 16'h0000);
      for (int w = 0; w < 100; w++)
         for (int d = 0; d < 12; d++)
         begin
            dig(5'h01);
            chk("even_sel", w % 2 ? 16'h0000 : 16'h0001 << d, esel);
            chk("odd_sel", w % 2 ? 16'h0001 << d : 16'h0000, osel);
            chk("word_odd", 16'((d == 11 ? w + 1 : w) % 2), wod);
            if (d == 10)
               chk("request", 16'h0001, req);
         end
      chk("subtract", 16'h0003, sub);
      chk("enable", 16'h0000, en);
      repeat (12) @(posedge CLOCK_I);
      #1;
      chk("hundred", 16'h0001, hund);
      chk("word_even", 16'h0001, wev);
      chk("grants", 16'h0064, acks);
      chk("mem_addr", 16'h0064 - 16'h09C3, addr);
      rd(4'h4, 16'h001C);
      rd(4'h8, 16'h6400);
      pulse(12'h004);
      chk("subtract", 16'h0000, sub);
   endtask

   task automatic t_errors;
      for (int i = 4; i < 7; i++)
      begin
         pulse(12'h001);
         chk("enable", 16'h0001, en);
         pulse(12'h001 << i);
         chk("enable", 16'h0000, en);
         // Error insert forces the sector end over a digit with odd ones
         if (i == 6)
            chk("chk_fault", 16'h0001, pf);
      end
      wr(4'hC, 16'h000F);
      pulse(12'h280);
      chk("start_err", 16'h0001, se);
      pulse(12'hC82);
      chk("late_start", 16'h0001, se);
      pulse(12'h300);
      chk("cont_err", 16'h0000, ce);
      pulse(12'h100);
      chk("cont_err", 16'h0001, ce);
      dig(5'h03);
      chk("parity", 16'h0001, pe);
      chk("sel_gated", 16'h0000, osel | esel);
      dig(5'h17);
      chk("parity", 16'h0000, pe);
      chk("sector_end", 16'h0001, eos);
      chk("digit_out", 16'h0017, adig);
      chk("chk_fault", 16'h0000, pf);
      rd(4'hC, 16'h0007);
      wr(4'hC, 16'h000F);
      rd(4'hC, 16'h0000);
   endtask

   initial
   begin
      RST_N_I = 1'b0;
      WR_I    = 1'b0;
      RD_I    = 1'b0;
      ADDR_I  = 4'h0;
      WDATA_I = 16'h0000;
      rdy     = 5'h00;
      bits    = 5'h00;
      ctl     = 12'h000;
      fails   = 0;
      checked = 0;
      repeat (3) @(posedge CLOCK_I);
      RST_N_I <= 1'b1;
      t_regs;
      t_sector;
      t_errors;
      report_and_stop;
   end

   // A hang anywhere ends the run as a mismatch
   initial
   begin
      #1000000;
      fails++;
      report_and_stop;
   end
endmodule // tb
`default_nettype wire
